// *** clock_gen_pkg.sv ***
//==========================================================================
// Functional notes
// - reset runs from internal oscillator; software picks external
// - base mode: free vco divided by k
// - prescaler mode: oscillator divided by p times k
// - pll mode: oscillator times n over p times k
// - p fixed at one; n, k programmable
// - report oscillator loss and pll loss of lock
// - all clocks from system clock; cpu, peripheral 24
// - flash gets 48 and 24 mhz clocks
// - divided clock output on one of two pins
// - toggle latch halves clock output, 50 percent duty
// - idle stops cpu clock, peripherals keep running
// - slow-down divides cpu and peripherals by common factor
// - power-down switches off oscillator and pll
// - reset enters active; power modes only by software
// - software stops each peripheral clock separately
// - power-down exits by wake-up reset, ram kept
package clock_gen_pkg;

  //==========================================================================
  // register map (index on the address port)
  localparam int unsigned ADDR_W       = 3;
  localparam int unsigned DATA_W       = 8;
  localparam logic [2:0]  REG_CTRL     = 3'h0;
  localparam logic [2:0]  REG_FB_DIV   = 3'h1;
  localparam logic [2:0]  REG_OUT_DIV  = 3'h2;
  localparam logic [2:0]  REG_CLKCON   = 3'h3;
  localparam logic [2:0]  REG_PMODE    = 3'h4;
  localparam logic [2:0]  REG_STOP     = 3'h5;
  localparam logic [2:0]  REG_STATUS   = 3'h6;

  // control register fields
  localparam int unsigned CTRL_EXT     = 0;
  localparam int unsigned CTRL_VCOBYP  = 1;
  localparam int unsigned CTRL_OSCDIS  = 2;
  localparam int unsigned CTRL_FAST48  = 3;
  localparam int unsigned CTRL_TOGGLE  = 4;
  localparam int unsigned CTRL_PINSEL  = 5;

  // status register fields
  localparam int unsigned ST_OSC_OK    = 0;
  localparam int unsigned ST_LOCKED    = 1;
  localparam int unsigned ST_OSC_FAIL  = 2;
  localparam int unsigned ST_LOCK_LOST = 3;
  localparam int unsigned ST_MODE_LSB  = 4;

  // reset values: internal oscillator, n 20, k 2 gives 96 mhz
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [5:0]  FB_DIV_RST   = 6'h14;
  localparam logic [3:0]  OUT_DIV_RST  = 4'h2;
  localparam logic [7:0]  CLKCON_RST   = 8'h00;
  localparam logic [7:0]  STOP_RST     = 8'h00;
  localparam logic [5:0]  P_FACTOR     = 6'h01;

  // fixed ratios below the system clock (divide by value plus one)
  localparam logic [7:0]  DIV_FLASH2X  = 8'h01;
  localparam logic [7:0]  DIV_CPU      = 8'h03;
  localparam int unsigned NUM_PERIPH   = 8;

  // phase accumulators for on-chip sources, step per 8 ns cycle
  localparam int unsigned CLK_MHZ10    = 1250;
  localparam logic [10:0] INT_OSC_STEP = 11'h060;
  localparam logic [10:0] VCO_BASE_STEP = 11'h190;
  localparam logic [10:0] PHASE_MOD    = 11'h4E2;

  // supervision times
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned OSC_TIMEOUT_NS = 1000;
  localparam int unsigned LOCK_TIME_NS  = 2000;
  localparam int unsigned OSC_TIMEOUT_CYC =
    OSC_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned LOCK_CYC =
    (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    PM_ACTIVE,
    PM_IDLE,
    PM_SLOW,
    PM_PDOWN
  } pmode_t;

endpackage

// *** clock_gen_unit.sv ***
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/100ps
//==========================================================================
// clock generation and power-mode control; every derived clock is a
// one-cycle enable pulse on clk, except the toggled level on the clock output pin
module clock_gen_unit (
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic [clock_gen_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [clock_gen_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic [clock_gen_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                      ext_osc_in,
  input  wire logic                      wake_pin,
  input  wire logic                      idle_exit,
  output logic                           sys_clk_en,
  output logic                           cpu_clk,
  output logic                           fast_clk,
  output logic                           flash_fast_clk,
  output logic                           flash_cpu_clk,
  output logic [clock_gen_pkg::NUM_PERIPH-1:0] periph_clk_en,
  output logic                           clock_output_pin_p0_out,
  output logic                           clock_output_pin_p0_oe,
  output logic                           clock_output_pin_p7_out,
  output logic                           clock_output_pin_p7_oe,
  output logic                           osc_enable,
  output logic                           pll_enable,
  output logic                           osc_fail_flag,
  output logic                           lock_lost_flag,
  output logic                           wake_reset_req,
  output logic                           ram_retain
);
  import clock_gen_pkg::*;

  //==========================================================================
  // software registers
  logic [7:0] ctrl_q;
  logic [5:0] fb_div_q;
  logic [3:0] out_div_q;
  logic [7:0] clkcon_q;
  logic [7:0] stop_q;
  pmode_t     mode_q;
  logic       osc_ok_q;
  logic       locked_q;

  function automatic logic wr_hit(input logic [2:0] idx);
    wr_hit = reg_wr && (reg_addr == idx);
  endfunction

  // configuration writes; modes are handled with the mode machine
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_q   <= CTRL_RST;
      fb_div_q  <= FB_DIV_RST;
      out_div_q <= OUT_DIV_RST;
      clkcon_q <= CLKCON_RST;
      stop_q   <= STOP_RST;
    end else begin
      if (wr_hit(REG_CTRL))   ctrl_q   <= reg_wdata;
      if (wr_hit(REG_FB_DIV))  fb_div_q <= reg_wdata[5:0];
      if (wr_hit(REG_OUT_DIV)) out_div_q <= reg_wdata[3:0];
      if (wr_hit(REG_CLKCON)) clkcon_q <= reg_wdata;
      if (wr_hit(REG_STOP))   stop_q   <= reg_wdata;
    end
  end

  //==========================================================================
  // power-mode machine
  logic wake_s;
  logic wake_d1_q;

  sync2 u_wake_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       (wake_pin),
    .q       (wake_s)
  );

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wake_d1_q <= 1'b0;
    end else begin
      wake_d1_q <= wake_s;
    end
  end

  // leaving power-down is only by the wake-up reset the system issues
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode_q <= PM_ACTIVE;
    end else begin
      case (mode_q)
        PM_ACTIVE: begin
          if (wr_hit(REG_PMODE)) begin
            case (reg_wdata[1:0])
              2'h1:    mode_q <= PM_IDLE;
              2'h2:    mode_q <= PM_SLOW;
              2'h3:    mode_q <= PM_PDOWN;
              default: mode_q <= PM_ACTIVE;
            endcase
          end
        end
        PM_IDLE: begin
          if (idle_exit) mode_q <= PM_ACTIVE;
        end
        PM_SLOW: begin
          if (wr_hit(REG_PMODE) && reg_wdata[1:0] == 2'h0) begin
            mode_q <= PM_ACTIVE;
          end
        end
        PM_PDOWN: mode_q <= PM_PDOWN;
        default:  mode_q <= PM_ACTIVE;
      endcase
    end
  end

  // wake request holds until the reset it asks for arrives
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wake_reset_req <= 1'b0;
      ram_retain     <= 1'b0;
      osc_enable     <= 1'b1;
      pll_enable     <= 1'b1;
    end else begin
      if (mode_q == PM_PDOWN && wake_s && !wake_d1_q) begin
        wake_reset_req <= 1'b1;
        ram_retain     <= 1'b1;
      end
      osc_enable <= (mode_q != PM_PDOWN);
      pll_enable <= (mode_q != PM_PDOWN);
    end
  end

  //==========================================================================
  // oscillator sources
  logic        ext_s;
  logic        ext_d1_q;
  logic        ext_tick;
  logic [10:0] int_phase_q;
  logic [10:0] vco_phase_q;
  logic        int_tick_q;
  logic        vco_tick_q;
  logic        run;

  assign run = (mode_q != PM_PDOWN);

  sync2 u_ext_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       (ext_osc_in),
    .q       (ext_s)
  );

  // on-chip oscillator and free-running vco as phase accumulators
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ext_d1_q    <= 1'b0;
      int_phase_q <= 11'h000;
      vco_phase_q <= 11'h000;
      int_tick_q  <= 1'b0;
      vco_tick_q  <= 1'b0;
    end else begin
      ext_d1_q   <= ext_s;
      int_tick_q <= 1'b0;
      vco_tick_q <= 1'b0;
      if (run) begin
        if (int_phase_q + INT_OSC_STEP >= PHASE_MOD) begin
          int_phase_q <= int_phase_q + INT_OSC_STEP - PHASE_MOD;
          int_tick_q  <= 1'b1;
        end else begin
          int_phase_q <= int_phase_q + INT_OSC_STEP;
        end
        if (vco_phase_q + VCO_BASE_STEP >= PHASE_MOD) begin
          vco_phase_q <= vco_phase_q + VCO_BASE_STEP - PHASE_MOD;
          vco_tick_q  <= 1'b1;
        end else begin
          vco_phase_q <= vco_phase_q + VCO_BASE_STEP;
        end
      end
    end
  end

  assign ext_tick = ext_s && !ext_d1_q && run;

  //==========================================================================
  // system clock: credits added per source tick, spent k at a time
  logic       ext_sel_q;
  logic       vcobyp_q;
  logic       oscdis_q;
  logic [5:0] n_act_q;
  logic [3:0] k_act_q;
  logic [9:0] credit_q;
  logic [9:0] k_cost;
  logic [9:0] add;
  logic       osc_tick;
  logic       spend;

  assign osc_tick = ext_sel_q ? ext_tick : int_tick_q;
  assign k_cost   = {4'h0, P_FACTOR} *
                    {6'h00, (k_act_q == 4'h0) ? 4'h1 : k_act_q};
  assign spend    = (credit_q >= k_cost);

  always_comb begin
    add = 10'h000;
    if (oscdis_q) begin
      add = {9'h000, vco_tick_q};
    end else if (vcobyp_q) begin
      add = {9'h000, osc_tick};
    end else if (osc_tick) begin
      add = {4'h0, n_act_q};
    end
  end

  // settings switch over only with no credit pending
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ext_sel_q  <= CTRL_RST[CTRL_EXT];
      vcobyp_q   <= CTRL_RST[CTRL_VCOBYP];
      oscdis_q   <= CTRL_RST[CTRL_OSCDIS];
      n_act_q    <= FB_DIV_RST;
      k_act_q    <= OUT_DIV_RST;
      credit_q   <= 10'h000;
      sys_clk_en <= 1'b0;
    end else begin
      sys_clk_en <= spend;
      if (!spend && add == 10'h000 && credit_q == 10'h000) begin
        ext_sel_q <= ctrl_q[CTRL_EXT];
        vcobyp_q  <= ctrl_q[CTRL_VCOBYP];
        oscdis_q  <= ctrl_q[CTRL_OSCDIS];
        n_act_q   <= fb_div_q;
        k_act_q   <= out_div_q;
      end
      credit_q <= credit_q + add - (spend ? k_cost : 10'h000);
    end
  end

  //==========================================================================
  // oscillator watch and lock detection
  logic [15:0] osc_idle_q;
  logic [15:0] lock_cnt_q;
  logic        pll_mode;

  assign pll_mode = !oscdis_q && !vcobyp_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      osc_idle_q <= 16'h0000;
      osc_ok_q   <= 1'b1;
    end else if (!run || osc_tick) begin
      osc_idle_q <= 16'h0000;
      osc_ok_q   <= 1'b1;
    end else if (osc_idle_q >= 16'(OSC_TIMEOUT_CYC)) begin
      osc_ok_q   <= 1'b0;
    end else begin
      osc_idle_q <= osc_idle_q + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lock_cnt_q <= 16'h0000;
      locked_q   <= 1'b0;
    end else if (!pll_mode || !osc_ok_q || !run ||
                 n_act_q != fb_div_q) begin
      lock_cnt_q <= 16'h0000;
      locked_q   <= 1'b0;
    end else if (lock_cnt_q >= 16'(LOCK_CYC)) begin
      locked_q   <= 1'b1;
    end else begin
      lock_cnt_q <= lock_cnt_q + 16'h0001;
    end
  end

  // sticky failures; a new event wins over a write-one clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      osc_fail_flag  <= 1'b0;
      lock_lost_flag <= 1'b0;
    end else begin
      if (osc_ok_q && osc_idle_q >= 16'(OSC_TIMEOUT_CYC) && run) begin
        osc_fail_flag <= 1'b1;
      end else if (wr_hit(REG_STATUS) && reg_wdata[ST_OSC_FAIL]) begin
        osc_fail_flag <= 1'b0;
      end
      if (locked_q && pll_mode && run && !osc_ok_q) begin
        lock_lost_flag <= 1'b1;
      end else if (wr_hit(REG_STATUS) && reg_wdata[ST_LOCK_LOST]) begin
        lock_lost_flag <= 1'b0;
      end
    end
  end

  //==========================================================================
  // derived clocks
  logic       flash2x_tick;
  logic       cpu_base_tick;
  logic       slow_tick;
  logic       core_tick;
  logic [7:0] slow_ratio;

  tick_divider u_div_flash2x (
    .clk      (clk),
    .reset_n  (reset_n),
    .tick_in  (sys_clk_en),
    .ratio    (DIV_FLASH2X),
    .tick_out (flash2x_tick)
  );

  tick_divider u_div_cpu (
    .clk      (clk),
    .reset_n  (reset_n),
    .tick_in  (sys_clk_en),
    .ratio    (DIV_CPU),
    .tick_out (cpu_base_tick)
  );

  // slow-down applies one common factor to cpu and peripherals
  assign slow_ratio = (mode_q == PM_SLOW) ?
                      {4'h0, clkcon_q[7:4]} : 8'h00;

  tick_divider u_div_slow (
    .clk      (clk),
    .reset_n  (reset_n),
    .tick_in  (cpu_base_tick),
    .ratio    (slow_ratio),
    .tick_out (slow_tick)
  );

  assign core_tick = slow_tick;

  // flash keeps its rates in idle and slow-down; cpu stops in idle and power-down
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cpu_clk        <= 1'b0;
      fast_clk       <= 1'b0;
      flash_fast_clk <= 1'b0;
      flash_cpu_clk  <= 1'b0;
    end else begin
      cpu_clk        <= core_tick && (mode_q == PM_ACTIVE ||
                                      mode_q == PM_SLOW);
      fast_clk       <= ctrl_q[CTRL_FAST48] ? flash2x_tick
                                             : cpu_base_tick;
      flash_fast_clk <= flash2x_tick;
      flash_cpu_clk  <= cpu_base_tick;
    end
  end

  // each peripheral enable is gated by its own stop bit
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_periph
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          periph_clk_en[gi] <= 1'b0;
        end else begin
          periph_clk_en[gi] <= core_tick && !stop_q[gi];
        end
      end
    end
  endgenerate

  //==========================================================================
  // clock output pin
  logic clock_output_pin_tick;
  logic toggle_q;
  logic clock_output_pin_lvl;

  tick_divider u_div_clock_output_pin (
    .clk      (clk),
    .reset_n  (reset_n),
    .tick_in  (sys_clk_en),
    .ratio    ({4'h0, clkcon_q[3:0]}),
    .tick_out (clock_output_pin_tick)
  );

  // the toggle latch gives equal high and low time
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      toggle_q <= 1'b0;
    end else if (clock_output_pin_tick) begin
      toggle_q <= !toggle_q;
    end
  end

  assign clock_output_pin_lvl = ctrl_q[CTRL_TOGGLE] ? toggle_q : clock_output_pin_tick;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      clock_output_pin_p0_out <= 1'b0;
      clock_output_pin_p0_oe  <= 1'b0;
      clock_output_pin_p7_out <= 1'b0;
      clock_output_pin_p7_oe  <= 1'b0;
    end else begin
      clock_output_pin_p0_out <= clock_output_pin_lvl && !ctrl_q[CTRL_PINSEL];
      clock_output_pin_p0_oe  <= !ctrl_q[CTRL_PINSEL];
      clock_output_pin_p7_out <= clock_output_pin_lvl && ctrl_q[CTRL_PINSEL];
      clock_output_pin_p7_oe  <= ctrl_q[CTRL_PINSEL];
    end
  end

  //==========================================================================
  // read port, data in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:   reg_rdata <= ctrl_q;
        REG_FB_DIV:  reg_rdata <= {2'h0, fb_div_q};
        REG_OUT_DIV: reg_rdata <= {4'h0, out_div_q};
        REG_CLKCON: reg_rdata <= clkcon_q;
        REG_PMODE:  reg_rdata <= {6'h00, mode_q};
        REG_STOP:   reg_rdata <= stop_q;
        REG_STATUS: reg_rdata <= {2'h0, mode_q, lock_lost_flag,
                                  osc_fail_flag, locked_q, osc_ok_q};
        default:    reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

// *** clock_gen_unit_asserts.sv ***
`timescale 1ns/100ps
//==========================================================================
// port checker for the clock unit
module clock_gen_unit_asserts (
  input wire logic                      clk,
  input wire logic                      reset_n,
  input wire logic [clock_gen_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [clock_gen_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [clock_gen_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                      cpu_clk,
  input wire logic                      fast_clk,
  input wire logic                      flash_fast_clk,
  input wire logic                      flash_cpu_clk,
  input wire logic [clock_gen_pkg::NUM_PERIPH-1:0] periph_clk_en,
  input wire logic                      clock_output_pin_p0_oe,
  input wire logic                      clock_output_pin_p7_oe,
  input wire logic                      osc_enable,
  input wire logic                      pll_enable,
  input wire logic                      osc_fail_flag,
  input wire logic                      wake_reset_req,
  input wire logic                      ram_retain
);
  import clock_gen_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // a quarter-rate clock needs four system ticks, at most one per cycle
  sequence s_gap3(logic x); !x [*3]; endsequence
  property p_cpu_gap; cpu_clk |=> s_gap3(cpu_clk); endproperty
  a_cpu_gap: assert property (p_cpu_gap)
    else $error("cpu pulses too close");
  property p_fcpu_gap; flash_cpu_clk |=> s_gap3(flash_cpu_clk); endproperty
  a_fcpu_gap: assert property (p_fcpu_gap)
    else $error("flash cpu pulses too close");
  property p_ffast_gap; flash_fast_clk |=> !flash_fast_clk; endproperty
  a_ffast_gap: assert property (p_ffast_gap)
    else $error("flash fast pulses adjacent");
  property p_fast_gap; fast_clk |=> !fast_clk; endproperty
  a_fast_gap: assert property (p_fast_gap)
    else $error("fast pulses adjacent");
  property p_per_gap;
    periph_clk_en[0] |=> s_gap3(periph_clk_en[0]);
  endproperty
  a_per_gap: assert property (p_per_gap)
    else $error("peripheral pulses too close");
  // both sources drop together, and no cpu pulse while they are off
  property p_osc_pll;
    osc_enable == pll_enable && (osc_enable || !cpu_clk);
  endproperty
  a_osc_pll: assert property (p_osc_pll)
    else $error("oscillator and pll enables differ");
  property p_one_pin; !(clock_output_pin_p0_oe && clock_output_pin_p7_oe); endproperty
  a_one_pin: assert property (p_one_pin)
    else $error("clock out on both pins");
  property p_wake;
    $rose(wake_reset_req) |-> !osc_enable && ram_retain;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake outside power-down");
  property p_retain; wake_reset_req |-> ram_retain; endproperty
  a_retain: assert property (p_retain)
    else $error("ram retain missing");
  // the flag only drops on a write of one to its status bit
  property p_fail_sticky;
    osc_fail_flag && !(reg_wr && reg_addr == REG_STATUS
      && reg_wdata[ST_OSC_FAIL]) |=> osc_fail_flag;
  endproperty
  a_fail_sticky: assert property (p_fail_sticky)
    else $error("oscillator fail flag lost");
  property p_boot; $rose(reset_n) |-> osc_enable && !cpu_clk; endproperty
  a_boot: assert property (p_boot)
    else $error("wrong state after reset");
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
endmodule
bind clock_gen_unit clock_gen_unit_asserts chk_i (.clk(clk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .cpu_clk(cpu_clk), .fast_clk(fast_clk), .flash_fast_clk(flash_fast_clk),
  .flash_cpu_clk(flash_cpu_clk), .periph_clk_en(periph_clk_en),
  .clock_output_pin_p0_oe(clock_output_pin_p0_oe), .clock_output_pin_p7_oe(clock_output_pin_p7_oe),
  .osc_enable(osc_enable), .pll_enable(pll_enable),
  .osc_fail_flag(osc_fail_flag), .wake_reset_req(wake_reset_req),
  .ram_retain(ram_retain));

// *** ext_osc_model.sv ***
`timescale 1ns/100ps
//==========================================================================
// external oscillator: 8 mhz square wave that the bench may stop through run
module ext_osc_model (
  input  wire logic run,
  output logic      osc_out
);
  logic lvl = 1'b0;

  assign osc_out = lvl;

  // a dead crystal parks low, so the loss detector sees no edges
  always begin
    #62.5;
    lvl = run ? ~lvl : 1'b0;
  end
endmodule

// *** sync2.sv ***
`timescale 1ns/100ps
//==========================================================================
// two flip-flop synchroniser for a level from outside the clock domain
module sync2 (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic d,
  output logic      q
);
  logic meta_q;

  // only the second stage is read by anything else
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// *** tb_top.sv ***
`timescale 1ns/100ps
//==========================================================================
// bench for the clock unit
module tb_top;
  import clock_gen_pkg::*;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       wake_pin = 1'b0;
  logic       idle_exit = 1'b0;
  logic       osc_run = 1'b1;
  logic [7:0] reg_rdata, per;
  logic       ext_osc_in, sys_clk_en, cpu_clk, fast_clk, ffast, fcpu;
  logic       p0, p0_oe, p7, p7_oe, osc_en, pll_en, ofail, lost, wake, ram;
  int         c[9];
  int         n_errors = 0;
  int         samples_checked = 0;

  ext_osc_model osc (.run(osc_run), .osc_out(ext_osc_in));
  clock_gen_unit uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_osc_in(ext_osc_in), .wake_pin(wake_pin),
    .idle_exit(idle_exit), .sys_clk_en(sys_clk_en), .cpu_clk(cpu_clk),
    .fast_clk(fast_clk), .flash_fast_clk(ffast), .flash_cpu_clk(fcpu),
    .periph_clk_en(per), .clock_output_pin_p0_out(p0), .clock_output_pin_p0_oe(p0_oe),
    .clock_output_pin_p7_out(p7), .clock_output_pin_p7_oe(p7_oe), .osc_enable(osc_en),
    .pll_enable(pll_en), .osc_fail_flag(ofail), .lock_lost_flag(lost),
    .wake_reset_req(wake), .ram_retain(ram));

  // 125 mhz
  always #4 clk = ~clk;

  //==========================================================================
  // shared tasks
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, s, e);
    end
  endtask
  // averaged rates jitter by a few ticks over the window
  task automatic near(input int g, input int e);
    chk(16'((g - e <= 4 && e - g <= 4) ? e : g), 16'(e));
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(16'(reg_rdata), 16'(e));
  endtask
  // count pulses over 1250 cycles, i.e. 10 us
  task automatic meas(input int settle);
    logic prev;
    logic bad;
    repeat (settle) @(posedge clk);
    c = '{default:0};
    bad = 1'b0;
    prev = p0;
    repeat (1250) begin
      @(posedge clk);
      #1;
      // an unknown would count as zero in the int tallies
      bad |= $isunknown({sys_clk_en, cpu_clk, fast_clk, ffast,
                         fcpu, per, p0});
      c[0] += sys_clk_en;
      c[1] += cpu_clk;
      c[2] += fast_clk;
      c[3] += ffast;
      c[4] += fcpu;
      c[5] += per[0];
      c[6] += per[1];
      c[7] += (p0 && !prev);
      c[8] += p0;
      prev = p0;
    end
    chk(16'(bad), 16'h0);
  endtask

  //==========================================================================
  // scenarios
  task automatic t_reset;
    rdchk(REG_CTRL, CTRL_RST);
    rdchk(REG_FB_DIV, 8'h14);
    rdchk(REG_OUT_DIV, 8'h02);
    rdchk(REG_PMODE, 8'h00);
    rdchk(REG_STOP, STOP_RST);
    wr(3'h7, 8'hFF);
    rdchk(3'h7, 8'h00);
  endtask
  task automatic t_pll;
    meas(300);
    near(c[0], 960);
    near(c[1], 240);
    near(c[5], 240);
    near(c[2], 240);
    near(c[3], 480);
    near(c[4], 240);
    wr(REG_CTRL, 8'h08);
    meas(20);
    near(c[2], 480);
    wr(REG_OUT_DIV, 8'h04);
    meas(20);
    near(c[0], 480);
    wr(REG_OUT_DIV, 8'h02);
    wr(REG_CTRL, 8'h02);
    meas(20);
    near(c[0], 48);
    wr(REG_CTRL, 8'h04);
    meas(20);
    near(c[0], 200);
  endtask
  task automatic t_ext;
    wr(REG_FB_DIV, 8'h18);
    wr(REG_CTRL, 8'h01);
    meas(300);
    near(c[0], 960);
  endtask
  task automatic t_power;
    wr(REG_CLKCON, 8'h10);
    wr(REG_PMODE, 8'h02);
    meas(20);
    near(c[1], 120);
    near(c[5], 120);
    wr(REG_PMODE, 8'h00);
    wr(REG_PMODE, 8'h01);
    meas(20);
    near(c[1], 0);
    near(c[5], 240);
    @(posedge clk);
    idle_exit <= 1'b1;
    @(posedge clk);
    idle_exit <= 1'b0;
    rdchk(REG_PMODE, 8'h00);
    wr(REG_STOP, 8'h01);
    meas(20);
    near(c[5], 0);
    near(c[6], 240);
    wr(REG_STOP, 8'h00);
  endtask
  task automatic t_clock_output_pin;
    wr(REG_CLKCON, 8'h03);
    // base mode puts every fourth system tick exactly 25 cycles apart, so each half period of the
    // halved output is a whole 25 cycles and the duty count is exact
    wr(REG_CTRL, 8'h14);
    meas(40);
    near(c[7], 25);
    near(c[8], 625);
    wr(REG_CTRL, 8'h01);
    meas(40);
    near(c[7], 240);
    wr(REG_CTRL, 8'h21);
    repeat (20) @(posedge clk);
    chk({p7_oe, p0_oe}, 16'h2);
  endtask
  task automatic t_fail_pdown;
    osc_run <= 1'b0;
    repeat (300) @(posedge clk);
    chk(ofail, 1'b1);
    chk(lost, 1'b1);
    osc_run <= 1'b1;
    wr(REG_CTRL, 8'h00);
    wr(REG_STATUS, 8'h0C);
    #1 chk({ofail, lost}, 16'h0);
    wr(REG_PMODE, 8'h03);
    repeat (5) @(posedge clk);
    chk({osc_en, pll_en}, 16'h0);
    wake_pin <= 1'b1;
    repeat (10) @(posedge clk);
    chk({wake, ram}, 16'h3);
    reset_n <= 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    wake_pin <= 1'b0;
    @(posedge clk);
    #1 chk({osc_en, wake}, 16'h2);
  endtask

  //==========================================================================
  // closing and main sequence
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // a hang is cut off well past the expected 15k cycles
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_pll();
    t_ext();
    t_power();
    t_clock_output_pin();
    t_fail_pdown();
    give_verdict();
  end
endmodule

// *** tick_divider.sv ***
`timescale 1ns/100ps
//==========================================================================
// divides a tick stream by ratio plus one; the ratio is reloaded only
// at the wrap so a change never shortens a period
module tick_divider (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       tick_in,
  input  wire logic [7:0] ratio,
  output logic            tick_out
);
  logic [7:0] cnt_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_q    <= 8'h00;
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_in && (cnt_q == 8'h00);
      if (tick_in) begin
        cnt_q <= (cnt_q == 8'h00) ? ratio : cnt_q - 8'h01;
      end
    end
  end
endmodule
